// file: cmpctl_defs.svh
// Constants for the comparator output control block.
// How it works
// R01: Comparator runs only while comparator_on is set.
// R02: Result readable in control and mirror register.
// R03: Pin shows result only with enable, output, on.
// R04: Pin enable overrides port latch regardless of on.
// R05: Internal result latched each cycle; pin path not. The code registers pin_out each cycle as well.
// R06: Invert bit zero passes, one complements the result.
// R07: Speed select resets to one, normal speed.
// R08: Hysteresis applied only while its enable set.
// R09: Result offered as gate timer gate source.
// R10: Sync mode captures result on timer falling edge.
// R11: Gate timer counts on rising clock edge.
// R12: Software should enable sync when gating timer.
// R13: Each instance has rise and fall detectors.
// R14: Enabled rise or fall edge sets interrupt flag.
// R15: Only software clears the interrupt flag.
// R16: Edge during a clear leaves flag set.
// R17: Software sets all enables to get interrupts.
// R18: Toggling invert, or on while the input is high, makes a real edge.
// R19: Four independent instances share the mirror register.
// R20: Edges compare current and previous latched result.
`ifndef CMPCTL_DEFS_SVH
`define CMPCTL_DEFS_SVH
`define CMPCTL_NUM_CMP 4
`define CMPCTL_CTRL_RESET 8'h10
`define CMPCTL_MIRROR_RESET 4'h0
`endif

// file: cmpctl_pkg.sv
// Types shared by the comparator output control block.
package cmpctl_pkg;
    typedef struct packed {
        logic comparator_on;
        logic pin_output_enable;
        logic output_invert;
        logic speed_power_select;
        logic hysteresis_enable;
        logic timer_sync_enable;
        logic rise_irq_enable;
        logic fall_irq_enable;
    } cmpctl_ctrl_t;

    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
        logic flag;
    } cmpctl_edge_t;

    typedef struct packed {
        cmpctl_ctrl_t [3:0] ctrl;
        logic [3:0] raw_s1;
        logic [3:0] raw_s2;
        logic [3:0] raw_s3;
        logic [3:0] raw_f;
        logic tclk_s1;
        logic tclk_s2;
        logic tclk_s3;
        logic tclk_f;
        logic [3:0] captured;
        logic [3:0] result;
        logic [3:0] mirror;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic [3:0] gate;
        logic [3:0] analog_on;
        logic [3:0] low_power;
        logic [3:0] hyst;
    } cmpctl_state_t;
endpackage

// file: cmpctl_edge.sv
// Edge detectors and sticky interrupt flag of one comparator.
`timescale 1ns/1ps
module cmpctl_edge (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_result,
    input wire logic i_rise_en,
    input wire logic i_fall_en,
    input wire logic i_flag_clear,
    output logic o_rise,
    output logic o_fall,
    output logic o_flag
);
    cmpctl_pkg::cmpctl_edge_t st;
    cmpctl_pkg::cmpctl_edge_t next_st;
    logic set_flag;

    always_comb begin
        next_st = st;
        next_st.prev = i_result;
        next_st.rise = i_result & ~st.prev; // [R13] [R20]
        next_st.fall = ~i_result & st.prev; // [R13] [R20]
        set_flag = (st.rise & i_rise_en) | (st.fall & i_fall_en); // [R14]
        next_st.flag = (st.flag & ~i_flag_clear) | set_flag; // [R15] [R16]
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rise = st.rise;
    assign o_fall = st.fall;
    assign o_flag = st.flag;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    chk_set_beats_clear: assert property ( // [R16]
        (st.rise & i_rise_en & i_flag_clear) |=> st.flag)
        else $error("Flag lost on edge during clear.");
    chk_flag_sticky: assert property ( // [R15]
        (st.flag & ~i_flag_clear) |=> st.flag)
        else $error("Flag cleared without software.");
    chk_edge_single: assert property ( // [R20]
        $rose(i_result) |=> o_rise ##1 ~o_rise)
        else $error("Rise pulse not exactly one cycle.");
    chk_fall_sets: assert property ( // [R14]
        (st.fall & i_fall_en) |=> st.flag)
        else $error("Enabled fall did not set flag.");
endmodule

// file: cmpctl_top.sv
// Digital control of four comparators: result, pin, gate and flags.
`timescale 1ns/1ps
`include "cmpctl_defs.svh"
module cmpctl_top #(
    parameter int NUM_CMP = `CMPCTL_NUM_CMP
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [3:0] i_raw_compare,
    input wire logic i_timer_clock,
    input wire logic [3:0] i_ctrl_write,
    input wire cmpctl_pkg::cmpctl_ctrl_t i_ctrl_data,
    input wire logic [3:0] i_pin_direction,
    input wire logic [3:0] i_port_latch,
    input wire logic [3:0] i_flag_clear,
    output cmpctl_pkg::cmpctl_ctrl_t [3:0] o_ctrl,
    output logic [3:0] o_comparator_result,
    output logic [3:0] o_result_mirror_reg,
    output logic [3:0] o_pin_out,
    output logic [3:0] o_pin_oe,
    output logic [3:0] o_gate_source,
    output logic [3:0] o_analog_on,
    output logic [3:0] o_low_power,
    output logic [3:0] o_hysteresis_on,
    output logic [3:0] o_rise_pulse,
    output logic [3:0] o_fall_pulse,
    output logic [3:0] o_compare_irq_flag
);
    cmpctl_pkg::cmpctl_state_t st;
    cmpctl_pkg::cmpctl_state_t next_st;
    logic [3:0] live;
    logic [3:0] pin_value;
    logic tclk_fall;

    always_comb begin
        next_st = st;
        live = '0;
        pin_value = '0;
        next_st.raw_s1 = i_raw_compare;
        next_st.raw_s2 = st.raw_s1;
        next_st.raw_s3 = st.raw_s2;
        next_st.tclk_s1 = i_timer_clock;
        next_st.tclk_s2 = st.tclk_s1;
        next_st.tclk_s3 = st.tclk_s2;
        if (st.tclk_s2 == st.tclk_s3) begin
            next_st.tclk_f = st.tclk_s3;
        end
        tclk_fall = st.tclk_f & (st.tclk_s2 == st.tclk_s3) & ~st.tclk_s3;
        for (int i = 0; i < NUM_CMP; i++) begin
            if (i_ctrl_write[i]) begin
                next_st.ctrl[i] = i_ctrl_data;
            end
            if (st.raw_s2[i] == st.raw_s3[i]) begin
                next_st.raw_f[i] = st.raw_s3[i];
            end
            // Disabled comparator output is low before polarity.
            live[i] = (st.ctrl[i].comparator_on & st.raw_f[i]) ^
                st.ctrl[i].output_invert; // [R01] [R06] [R18]
            next_st.result[i] = live[i]; // [R05] [R02]
            next_st.mirror[i] = live[i]; // [R02] [R19]
            if (tclk_fall) begin
                next_st.captured[i] = live[i]; // [R10]
            end
            pin_value[i] = st.ctrl[i].timer_sync_enable ?
                st.captured[i] : live[i]; // [R05] [R10]
            next_st.gate[i] = pin_value[i]; // [R09] [R10]
            if (st.ctrl[i].pin_output_enable) begin
                next_st.pin_out[i] = pin_value[i] &
                    st.ctrl[i].comparator_on; // [R03] [R04]
            end else begin
                next_st.pin_out[i] = i_port_latch[i]; // [R04]
            end
            next_st.pin_oe[i] = ~i_pin_direction[i]; // [R03]
            next_st.analog_on[i] = st.ctrl[i].comparator_on; // [R01]
            next_st.low_power[i] =
                ~st.ctrl[i].speed_power_select; // [R07]
            next_st.hyst[i] = st.ctrl[i].comparator_on &
                st.ctrl[i].hysteresis_enable; // [R08]
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.ctrl <= {4{`CMPCTL_CTRL_RESET}}; // [R07]
            st.mirror <= `CMPCTL_MIRROR_RESET;
        end else begin
            st <= next_st;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : gen_cmp
            cmpctl_edge u_edge (
                .i_clock(i_clock),
                .i_rst(i_rst),
                .i_result(st.result[g]),
                .i_rise_en(st.ctrl[g].rise_irq_enable),
                .i_fall_en(st.ctrl[g].fall_irq_enable),
                .i_flag_clear(i_flag_clear[g]),
                .o_rise(o_rise_pulse[g]),
                .o_fall(o_fall_pulse[g]),
                .o_flag(o_compare_irq_flag[g])
            ); // [R13] [R19]
        end
    endgenerate

    assign o_ctrl = st.ctrl;
    assign o_comparator_result = st.result;
    assign o_result_mirror_reg = st.mirror;
    assign o_pin_out = st.pin_out;
    assign o_pin_oe = st.pin_oe;
    assign o_gate_source = st.gate;
    assign o_analog_on = st.analog_on;
    assign o_low_power = st.low_power;
    assign o_hysteresis_on = st.hyst;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_tclk_fall;
        st.tclk_f ##1 ~st.tclk_f;
    endsequence

    sequence s_result_rise;
        ~o_comparator_result[0] ##1 o_comparator_result[0];
    endsequence

    sequence s_result_fall;
        o_comparator_result[0] ##1 ~o_comparator_result[0];
    endsequence

    chk_result_polarity: assert property ( // [R06]
        ##1 o_comparator_result[0] == $past((st.ctrl[0].comparator_on &
            st.raw_f[0]) ^ st.ctrl[0].output_invert))
        else $error("Result polarity wrong.");
    chk_mirror_match: assert property ( // [R02]
        o_result_mirror_reg == o_comparator_result)
        else $error("Mirror differs from result.");
    chk_pin_override: assert property ( // [R04]
        ~st.ctrl[1].pin_output_enable |=> o_pin_out[1] ==
            $past(i_port_latch[1]))
        else $error("Port latch not passed through.");
    chk_pin_gated_off: assert property ( // [R03]
        (st.ctrl[0].pin_output_enable & ~st.ctrl[0].comparator_on)
            |=> ~o_pin_out[0])
        else $error("Result reached pin while off.");
    chk_sync_hold: assert property ( // [R10]
        (st.ctrl[2].timer_sync_enable & ~tclk_fall) ##1
            st.ctrl[2].timer_sync_enable |=> $stable(o_gate_source[2]))
        else $error("Synced gate changed without timer fall.");
    chk_sync_capture: assert property ( // [R10]
        s_tclk_fall |=> st.captured[3] == $past(live[3], 2) ||
            !$past(tclk_fall, 2))
        else $error("Capture missed timer falling edge.");
    chk_low_power: assert property ( // [R07]
        ##1 o_low_power[0] == ~$past(st.ctrl[0].speed_power_select))
        else $error("Speed select not followed.");
    chk_hyst_off: assert property ( // [R08]
        ~st.ctrl[1].hysteresis_enable |=> ~o_hysteresis_on[1])
        else $error("Hysteresis on while disabled.");
    chk_invert_edge: assert property ( // [R18]
        (~st.ctrl[0].comparator_on & ~st.ctrl[0].output_invert &
            i_ctrl_write[0] & ~i_ctrl_data.comparator_on &
            i_ctrl_data.output_invert) |=> ##2 o_rise_pulse[0])
        else $error("Invert toggle gave no edge.");
    chk_result_off: assert property ( // [R01] [R18]
        ~st.ctrl[0].comparator_on |=>
            o_comparator_result[0] == $past(st.ctrl[0].output_invert))
        else $error("Disabled result does not follow invert.");
    chk_result_direct: assert property ( // [R06]
        (st.ctrl[1].comparator_on & ~st.ctrl[1].output_invert) |=>
            o_comparator_result[1] == $past(st.raw_f[1]))
        else $error("Plain result differs from comparator.");
    chk_result_inverted: assert property ( // [R06]
        (st.ctrl[1].comparator_on & st.ctrl[1].output_invert) |=>
            o_comparator_result[1] == ~$past(st.raw_f[1]))
        else $error("Inverted result differs from comparator.");
    chk_gate_async: assert property ( // [R09]
        ~st.ctrl[1].timer_sync_enable |=>
            o_gate_source[1] == o_comparator_result[1])
        else $error("Gate source differs from result.");
    chk_pin_follows: assert property ( // [R03] [R04]
        (st.ctrl[2].pin_output_enable & st.ctrl[2].comparator_on &
            ~st.ctrl[2].timer_sync_enable) |=>
            o_pin_out[2] == o_comparator_result[2])
        else $error("Pin does not show the result.");
    chk_oe_direction: assert property ( // [R03]
        1'b1 |=> o_pin_oe == ~$past(i_pin_direction))
        else $error("Pin drive does not follow direction.");
    chk_analog_enable: assert property ( // [R01]
        1'b1 |=> o_analog_on[3] == $past(st.ctrl[3].comparator_on))
        else $error("Analog enable does not follow on bit.");
    chk_hyst_on: assert property ( // [R08]
        (st.ctrl[3].comparator_on & st.ctrl[3].hysteresis_enable) |=>
            o_hysteresis_on[3])
        else $error("Hysteresis off while enabled.");
    chk_ctrl_load: assert property ( // [R19]
        i_ctrl_write[2] |=> o_ctrl[2] == $past(i_ctrl_data))
        else $error("Control write not stored.");
    chk_ctrl_keep: assert property ( // [R19]
        ~i_ctrl_write[2] |=> $stable(o_ctrl[2]))
        else $error("Control changed without a write.");
    chk_rise_pulse: assert property ( // [R13] [R20]
        s_result_rise |=> o_rise_pulse[0])
        else $error("Result rise gave no pulse.");
    chk_fall_pulse: assert property ( // [R13] [R20]
        s_result_fall |=> o_fall_pulse[0])
        else $error("Result fall gave no pulse.");
    chk_rise_flag: assert property ( // [R14]
        (s_result_rise ##1 st.ctrl[0].rise_irq_enable) |=>
            o_compare_irq_flag[0])
        else $error("Enabled rise did not set flag.");
    chk_fall_flag: assert property ( // [R14]
        (s_result_fall ##1 st.ctrl[0].fall_irq_enable) |=>
            o_compare_irq_flag[0])
        else $error("Enabled fall did not set flag.");
    chk_clear_works: assert property ( // [R15]
        (o_compare_irq_flag[0] & i_flag_clear[0] & ~o_rise_pulse[0] &
            ~o_fall_pulse[0]) |=> ~o_compare_irq_flag[0])
        else $error("Flag survived a clear with no edge.");
endmodule

// file: cmpctl_far.sv
// Far side: comparator cores, prescaled gate timer clock and gate timer.
`timescale 1ns/1ps
module cmpctl_far (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [3:0] i_level,
    input wire logic [3:0] i_gate,
    output logic [3:0] o_raw,
    output logic o_tclk,
    output logic [7:0] o_count
);
    logic [2:0] div;
    assign o_raw = i_level;
    // The timer clock stands low while the timer is stopped.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div <= 3'h0;
            o_tclk <= 1'b0;
        end else begin
            div <= i_run ? div + 3'h1 : 3'h0;
            o_tclk <= i_run & div[2];
        end
    end
    // The timer counts on the rising edge while gated open.
    always_ff @(posedge o_tclk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= 8'h00;
        end else if (|i_gate) begin
            o_count <= o_count + 8'h01;
        end
    end
endmodule

// file: cmpctl_top_tb.sv
// Self-checking testbench of the comparator output control block.
`timescale 1ns/1ps
module cmpctl_top_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic run = 1'b0;
    logic [3:0] lv = 4'h0, wr = 4'h0, dir = 4'hF, lat = 4'h0, clr = 4'h0;
    cmpctl_pkg::cmpctl_ctrl_t dat = 8'h00;
    cmpctl_pkg::cmpctl_ctrl_t [3:0] ctrl;
    logic [3:0] raw, res, mir, pin, poe, gate, aon, lowp, hys, rise, fall;
    logic [3:0] flag;
    logic tclk;
    logic [7:0] cnt;
    int failures = 0, total_checks = 0, nrise = 0, nfl = 0, nfall = 0;
    cmpctl_far far (.i_clock(i_clock), .i_rst(i_rst), .i_run(run),
        .i_level(lv), .i_gate(gate), .o_raw(raw), .o_tclk(tclk),
        .o_count(cnt));
    cmpctl_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_raw_compare(raw),
        .i_timer_clock(tclk), .i_ctrl_write(wr), .i_ctrl_data(dat),
        .i_pin_direction(dir), .i_port_latch(lat), .i_flag_clear(clr),
        .o_ctrl(ctrl), .o_comparator_result(res), .o_result_mirror_reg(mir),
        .o_pin_out(pin), .o_pin_oe(poe), .o_gate_source(gate),
        .o_analog_on(aon), .o_low_power(lowp), .o_hysteresis_on(hys),
        .o_rise_pulse(rise), .o_fall_pulse(fall), .o_compare_irq_flag(flag));
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        nrise += rise[0];
        nfall += fall[0];
        nfl += flag[0] & clr[0];
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic wrc(input int c, input logic [7:0] v);
        wr[c] = 1'b1;
        dat = v;
        tk(1);
        wr = 4'h0;
        tk(2);
    endtask
    task automatic t_reset;
        for (int c = 0; c < 4; c++) begin
            chk(ctrl[c], 16'h10);
        end
        chk({lowp, res, flag}, 16'h0);
    endtask
    task automatic t_power;
        wrc(3, 8'h88);
        chk({aon[3], lowp[3], hys[3]}, 16'h7);
        i_rst = 1'b1;
        tk(2);
        i_rst = 1'b0;
        chk(ctrl[3], 16'h10);
        chk({aon[3], lowp[3], hys[3]}, 16'h0);
        wrc(3, 8'h18);
        chk({aon[3], lowp[3], hys[3]}, 16'h0);
    endtask
    task automatic t_sync;
        wrc(3, 8'h94);
        lv[3] = 1'b1;
        tk(10);
        chk({res[3], gate[3]}, 16'h2);
        run = 1'b1;
        tk(60);
        run = 1'b0;
        tk(6);
        chk(gate[3], 16'h1);
        chk(cnt != 8'h00, 16'h1);
    endtask
    task automatic t_polarity;
        for (int k = 0; k < 4; k++) begin
            wrc(1, k[1] ? 8'hB0 : 8'h90);
            lv[1] = k[0];
            tk(8);
            chk({res[1], mir[1], gate[1]}, {13'h0, {3{k[0] ^ k[1]}}});
        end
    endtask
    task automatic t_pin;
        lv[2] = 1'b1;
        dir[2] = 1'b0;
        wrc(2, 8'hD0);
        tk(8);
        chk({poe[2], pin[2]}, 16'h3);
        wrc(2, 8'h70);
        tk(8);
        chk(pin[2], 16'h0);
        lat[2] = 1'b1;
        wrc(2, 8'h90);
        tk(4);
        chk(pin[2], 16'h1);
        dir[2] = 1'b1;
        tk(2);
        chk(poe[2], 16'h0);
    endtask
    task automatic t_irq;
        wrc(0, 8'h92);
        lv[0] = 1'b1;
        tk(10);
        chk({nrise[3:0], flag[0]}, 16'h3);
        tk(10);
        chk(flag[0], 16'h1);
        clr[0] = 1'b1;
        tk(1);
        clr[0] = 1'b0;
        tk(1);
        chk(flag[0], 16'h0);
        lv[0] = 1'b0;
        tk(10);
        chk(flag[0], 16'h0);
        chk(nfall[15:0], 16'h1);
        wrc(0, 8'h12);
        wrc(0, 8'h32);
        tk(6);
        chk(flag[0], 16'h1);
        clr[0] = 1'b1;
        tk(2);
        lv[0] = 1'b1;
        wrc(0, 8'h81);
        lv[0] = 1'b0;
        tk(10);
        clr[0] = 1'b0;
        chk(nfl != 0, 16'h1);
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge i_clock);
        failures++;
        summarize();
    end
    initial begin
        tk(5);
        i_rst = 1'b0;
        t_reset();
        t_power();
        t_sync();
        t_polarity();
        t_pin();
        t_irq();
        summarize();
    end
endmodule
